// File: rtl/dgc_defs.svh
// register indices, field positions, reset values and counts
`ifndef DGC_DEFS_SVH
`define DGC_DEFS_SVH
`define DGC_IDX_PINS       8'h08
`define DGC_IDX_RSVD       8'h09
`define DGC_IDX_CLKCTL     8'h0A
`define DGC_IDX_ROUTE      8'h0B
`define DGC_IDX_EVENTS     8'h40
`define DGC_IDX_PINLVL     8'h41
`define DGC_RST_PINS       8'h10
`define DGC_RST_RSVD       8'h00
`define DGC_RST_CLKCTL     8'h05
`define DGC_RST_ROUTE      8'h02
`define DGC_FN_MUTE        4'h0
`define DGC_FN_LOCK        4'h1
`define DGC_FN_MINVOL      4'h2
`define DGC_FN_REFCLK      4'h3
`define DGC_FN_LOCK_IRQ    4'h4
`define DGC_FN_MUTE_IRQ    4'h5
`define DGC_FN_ANY_IRQ     4'h6
`define DGC_FN_LOW         4'h7
`define DGC_FN_IN_LEVEL    4'h8
`define DGC_FN_IN_SELECT   4'h9
`define DGC_FN_HIGH        4'hF
`define DGC_CK_MASTER      7
`define DGC_CK_DIV_HI      6
`define DGC_CK_DIV_LO      5
`define DGC_CK_QUICK       4
`define DGC_RT_SRC_HI      6
`define DGC_RT_SRC_LO      4
`define DGC_RT_RSWAP       3
`define DGC_RT_LSWAP       2
`define DGC_RT_SLOT_B      1
`define DGC_RT_SLOT_A      0
`define DGC_BITS_PER_FRAME 7'h40
`define DGC_ACQ_FULL       15'h4000
`define DGC_ACQ_QUICK      15'h0004
`define DGC_RESP_OKAY      2'h0
`define DGC_RESP_SLVERR    2'h2
`endif

// File: rtl/dgc_pkg.sv
// types shared by the clock, pin and routing configuration block
package dgc_pkg;
    // status levels from the converter core, same clock
    typedef struct packed {
        logic automute;
        logic locked;
        logic vol_min_left;
        logic vol_min_right;
        logic pcm_normal;
        logic ratio_128;
    } dgc_stat_s;
    // routing and lock controls handed to the core
    typedef struct packed {
        logic spdif_stream;
        logic slot_a_source;
        logic slot_b_source;
        logic left_pair_swap;
        logic right_pair_swap;
        logic lock_permit;
        logic input_select;
    } dgc_route_s;
    // write channel progress
    typedef enum logic [1:0] {WR_IDLE, WR_HAVE, WR_RESP} dgc_wr_e;
endpackage : dgc_pkg

// File: rtl/dgc_top.sv
// pin function, master clock, lock acquisition and routing registers
//
// Summary of operation
// - function 0: pin follows automute
// - function 1: pin follows lock state
// - function 2: pin high at both minimum volumes
// - function 4: interrupt on lock change
// - function 5: interrupt on automute change
// - function 6: interrupt on either change
// - reading event register clears pin interrupts
// - function 8: input, level readable
// - function 9: input selects source
// - master bit drives bit and frame clocks
// - bit clock is reference over 4/8/16/16
// - frame clock is bit clock over 64
// - clocks leave on bit clock, line one
// - quick bit gives fast synchronous lock
// - lock waits 16384/(code+1) frame edges
// - consumer serial source from five pins
// - swap bits exchange converter output pair
// - slot source bits pick left or right
// - pin b upper nibble, pin a lower
//
// The AXI4-Lite interface to the registers is this design's own decision.
`include "dgc_defs.svh"
module dgc_top
    import dgc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // axi4-lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // converter core status and controls
    input  wire dgc_stat_s   core_stat,
    output dgc_route_s       core_route,
    // general pins
    input  wire logic        general_pin_a_i,
    output logic             general_pin_a_o,
    output logic             general_pin_a_oe,
    input  wire logic        general_pin_b_i,
    output logic             general_pin_b_o,
    output logic             general_pin_b_oe,
    // serial audio pins
    input  wire logic        bit_clock_pin_i,
    output logic             bit_clock_pin_o,
    output logic             bit_clock_pin_oe,
    input  wire logic        serial_line_one_pin_i,
    output logic             serial_line_one_pin_o,
    output logic             serial_line_one_pin_oe,
    input  wire logic        serial_line_two_pin_i
);

    // register storage
    logic [7:0]  pin_cfg;        // pin b function high, pin a low
    logic [7:0]  rsvd_slot;      // kept, no effect
    logic [7:0]  clk_ctl;        // master, divider, quick, edge code
    logic [7:0]  route_cfg;      // source, swaps, slot sources
    logic        lock_evt;       // sticky lock change
    logic        mute_evt;       // sticky automute change
    logic        lock_d;         // previous lock level
    logic        mute_d;         // previous automute level
    logic        ref_half;       // reference clock image
    logic [4:0]  pin_s1;         // first synchroniser stage
    logic [4:0]  pin_s2;         // second synchroniser stage
    logic        frame_in_d;     // previous synced frame level
    logic [2:0]  div_cnt;        // bit clock half period count
    logic [4:0]  bit_cnt;        // bit clocks per frame half
    logic        bclk_gen;       // generated bit clock
    logic        fclk_gen;       // generated frame clock
    logic        fclk_gen_d;     // previous generated frame
    logic [14:0] acq_cnt;        // frame edges seen
    dgc_wr_e     wr_state;       // write progress
    logic [11:0] wr_addr;        // latched write address
    logic [31:0] wr_data;        // latched write data
    logic        aw_have;        // address taken
    logic        w_have;         // data taken

    // synced pins: a, b, bit clock, line one, line two
    wire [4:0] pin_raw = {serial_line_two_pin_i, serial_line_one_pin_i,
                          bit_clock_pin_i, general_pin_b_i,
                          general_pin_a_i};

    // field views
    wire [3:0] fn_a    = pin_cfg[3:0];
    wire [3:0] fn_b    = pin_cfg[7:4];
    wire       master  = clk_ctl[`DGC_CK_MASTER];
    wire [1:0] div_sel = clk_ctl[`DGC_CK_DIV_HI:`DGC_CK_DIV_LO];
    wire [3:0] acq_code = clk_ctl[3:0];
    wire [2:0] src_sel = route_cfg[`DGC_RT_SRC_HI:`DGC_RT_SRC_LO];

    // pin drive for one function code
    function automatic logic pin_drive(input logic [3:0] fn,
                                       input dgc_stat_s st,
                                       input logic le, input logic me,
                                       input logic rc);
        logic v;
        v = 1'b0;
        case (fn)
            `DGC_FN_MUTE:     v = st.automute;
            `DGC_FN_LOCK:     v = st.locked;
            `DGC_FN_MINVOL:   v = st.vol_min_left & st.vol_min_right;
            `DGC_FN_REFCLK:   v = rc;
            `DGC_FN_LOCK_IRQ: v = le;
            `DGC_FN_MUTE_IRQ: v = me;
            `DGC_FN_ANY_IRQ:  v = le | me;
            `DGC_FN_HIGH:     v = 1'b1;
            default:          v = 1'b0;
        endcase
        return v;
    endfunction : pin_drive

    // pin is input for codes 8 and 9
    function automatic logic pin_is_in(input logic [3:0] fn);
        return fn == `DGC_FN_IN_LEVEL || fn == `DGC_FN_IN_SELECT;
    endfunction : pin_is_in

    // frame edges needed before lock
    function automatic logic [14:0] acq_edges(input logic [3:0] c);
        return 15'(32'(`DGC_ACQ_FULL) / (32'(c) + 32'h1));
    endfunction : acq_edges

    // bus decode
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire [7:0] wr_idx = wr_addr[9:2];
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire wr_hit_top = wr_addr[11:10] == 2'h0 && wr_addr[1:0] == 2'h0;
    wire rd_hit_top = s_axi_araddr[11:10] == 2'h0
                      && s_axi_araddr[1:0] == 2'h0;
    wire do_write = (wr_state == WR_HAVE);
    wire wr_pins  = do_write && wr_hit_top && wr_idx == `DGC_IDX_PINS;
    wire wr_rsvd  = do_write && wr_hit_top && wr_idx == `DGC_IDX_RSVD;
    wire wr_clk   = do_write && wr_hit_top && wr_idx == `DGC_IDX_CLKCTL;
    wire wr_route = do_write && wr_hit_top && wr_idx == `DGC_IDX_ROUTE;
    wire wr_ok    = wr_pins | wr_rsvd | wr_clk | wr_route;
    wire [7:0] wr_byte = wr_data[7:0];
    wire wstrb0   = s_axi_wstrb[0];
    wire rd_evt   = ar_take && rd_hit_top && rd_idx == `DGC_IDX_EVENTS;

    // events and read clear, a new change beats the clear
    wire lock_chg = core_stat.locked != lock_d;
    wire mute_chg = core_stat.automute != mute_d;
    wire next_lock_evt = lock_chg | (lock_evt & ~rd_evt);
    wire next_mute_evt = mute_chg | (mute_evt & ~rd_evt);

    // read mux
    logic [7:0] rd_byte;
    logic       rd_ok;
    always_comb begin
        rd_ok   = rd_hit_top;
        rd_byte = 8'h00;
        unique case (rd_idx)
            `DGC_IDX_PINS:   rd_byte = pin_cfg;
            `DGC_IDX_RSVD:   rd_byte = rsvd_slot;
            `DGC_IDX_CLKCTL: rd_byte = clk_ctl;
            `DGC_IDX_ROUTE:  rd_byte = route_cfg;
            `DGC_IDX_EVENTS: rd_byte = {4'h0, core_stat.automute,
                                        core_stat.locked, mute_evt,
                                        lock_evt};
            `DGC_IDX_PINLVL: rd_byte = {6'h00, pin_s2[1], pin_s2[0]};
            default:         rd_ok   = 1'b0;
        endcase
    end

    // each write channel ready while its own beat is not held and no response is pending
    assign s_axi_awready = (wr_state != WR_RESP) & ~aw_have;
    assign s_axi_wready  = (wr_state != WR_RESP) & ~w_have;
    assign s_axi_arready = ~s_axi_rvalid;

    // write address/data gathering and response
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_state     <= WR_IDLE;
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            wr_addr      <= 12'h000;
            wr_data      <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DGC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have  <= 1'b1;
                wr_data <= wstrb0 ? s_axi_wdata : 32'h0000_0000;
            end
            unique case (wr_state)
                WR_IDLE: begin
                    if ((aw_have | aw_take) && (w_have | w_take))
                        wr_state <= WR_HAVE;
                end
                WR_HAVE: begin
                    wr_state     <= WR_RESP;
                    aw_have      <= 1'b0;
                    w_have       <= 1'b0;
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp  <= wr_ok ? `DGC_RESP_OKAY
                                          : `DGC_RESP_SLVERR;
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state     <= WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // register updates, byte lane 0 only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_cfg   <= `DGC_RST_PINS;
            rsvd_slot <= `DGC_RST_RSVD;
            clk_ctl   <= `DGC_RST_CLKCTL;
            route_cfg <= `DGC_RST_ROUTE;
        end else begin
            if (wr_pins)  pin_cfg   <= wr_byte;
            if (wr_rsvd)  rsvd_slot <= wr_byte;
            if (wr_clk)   clk_ctl   <= wr_byte;
            if (wr_route) route_cfg <= wr_byte;
        end
    end

    // read data channel
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `DGC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_ok ? rd_byte : 8'h00}; // bad reads 0
            s_axi_rresp  <= rd_ok ? `DGC_RESP_OKAY : `DGC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // pin synchronisers and event flags
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_s1   <= 5'h00;
            pin_s2   <= 5'h00;
            lock_d   <= core_stat.locked;    // no false change at release
            mute_d   <= core_stat.automute;
            lock_evt <= 1'b0;
            mute_evt <= 1'b0;
            ref_half <= 1'b0;
        end else begin
            pin_s1   <= pin_raw;
            pin_s2   <= pin_s1;
            lock_d   <= core_stat.locked;
            mute_d   <= core_stat.automute;
            lock_evt <= next_lock_evt;
            mute_evt <= next_mute_evt;
            ref_half <= ~ref_half;
        end
    end

    // general pin drivers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            general_pin_a_o  <= 1'b0;
            general_pin_b_o  <= 1'b0;
            general_pin_a_oe <= 1'b0;
            general_pin_b_oe <= 1'b0;
        end else begin
            general_pin_a_o  <= pin_drive(fn_a, core_stat, lock_evt,
                                          mute_evt, ref_half);
            general_pin_b_o  <= pin_drive(fn_b, core_stat, lock_evt,
                                          mute_evt, ref_half);
            general_pin_a_oe <= ~pin_is_in(fn_a);
            general_pin_b_oe <= ~pin_is_in(fn_b);
        end
    end

    // bit clock half period in reference cycles
    wire [2:0] half_len = (div_sel == 2'b00) ? 3'h2 :
                          (div_sel == 2'b01) ? 3'h4 : 3'h0;
    wire       div_wrap = (div_cnt == 3'(half_len - 3'h1)); // 0 means 8
    wire       bclk_fall = div_wrap & bclk_gen;
    wire [4:0] half_frame = 5'(`DGC_BITS_PER_FRAME / 7'h2 - 7'h1);

    // master clock generator
    always_ff @(posedge sys_clk) begin
        if (srst || !master) begin
            div_cnt  <= 3'h0;
            bit_cnt  <= 5'h00;
            bclk_gen <= 1'b0;
            fclk_gen <= 1'b0;
        end else begin
            div_cnt <= div_wrap ? 3'h0 : div_cnt + 3'h1;
            if (div_wrap)
                bclk_gen <= ~bclk_gen;
            if (bclk_fall) begin
                bit_cnt <= (bit_cnt == half_frame) ? 5'h00
                                                   : bit_cnt + 5'h01;
                if (bit_cnt == half_frame)
                    fclk_gen <= ~fclk_gen;
            end
        end
    end

    // clocks onto the serial pins in master mode
    assign bit_clock_pin_o        = bclk_gen;
    assign bit_clock_pin_oe       = master;
    assign serial_line_one_pin_o  = fclk_gen;
    assign serial_line_one_pin_oe = master;

    // frame edge counting for lock acquisition
    wire frame_lvl  = master ? fclk_gen : pin_s2[3];
    wire prev_lvl   = master ? fclk_gen_d : frame_in_d;
    wire frame_edge = frame_lvl & ~prev_lvl;
    wire quick      = clk_ctl[`DGC_CK_QUICK] & core_stat.pcm_normal
                      & core_stat.ratio_128;
    wire [14:0] acq_need = quick ? `DGC_ACQ_QUICK : acq_edges(acq_code);
    wire acq_done   = acq_cnt >= acq_need;
    always_ff @(posedge sys_clk) begin
        if (srst || wr_clk) begin
            acq_cnt    <= 15'h0000;
            frame_in_d <= pin_s2[3];         // level kept, no false edge
            fclk_gen_d <= fclk_gen;
        end else begin
            frame_in_d <= pin_s2[3];
            fclk_gen_d <= fclk_gen;
            if (frame_edge && !acq_done)
                acq_cnt <= acq_cnt + 15'h0001;
        end
    end

    // consumer serial source select
    logic spdif_bit;
    always_comb begin
        unique case (src_sel)
            3'h0:    spdif_bit = pin_s2[2];
            3'h1:    spdif_bit = pin_s2[4];
            3'h2:    spdif_bit = pin_s2[3];
            3'h3:    spdif_bit = pin_s2[0];
            3'h4:    spdif_bit = pin_s2[1];
            default: spdif_bit = 1'b0;
        endcase
    end

    // selection level from whichever pin is set to select
    wire sel_lvl = (fn_a == `DGC_FN_IN_SELECT) ? pin_s2[0] :
                   (fn_b == `DGC_FN_IN_SELECT) ? pin_s2[1] : 1'b0;

    // routing controls to the core
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            core_route <= '0;
        end else begin
            core_route.spdif_stream    <= spdif_bit;
            core_route.slot_a_source   <= route_cfg[`DGC_RT_SLOT_A];
            core_route.slot_b_source   <= route_cfg[`DGC_RT_SLOT_B];
            core_route.left_pair_swap  <= route_cfg[`DGC_RT_LSWAP];
            core_route.right_pair_swap <= route_cfg[`DGC_RT_RSWAP];
            core_route.lock_permit     <= acq_done;
            core_route.input_select    <= sel_lvl;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_pin_mute;
        fn_a == `DGC_FN_MUTE && $stable(fn_a) |=>
            general_pin_a_o == $past(core_stat.automute);
    endproperty
    a_pin_mute: assert property (p_pin_mute) else $error("pin a mute");
    property p_pin_lock;
        fn_b == `DGC_FN_LOCK |=> general_pin_b_o == $past(core_stat.locked);
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("pin b lock");
    property p_lock_irq;
        fn_a == `DGC_FN_LOCK_IRQ && lock_chg && !$past(srst)
            ##1 fn_a == `DGC_FN_LOCK_IRQ |=> general_pin_a_o;
    endproperty
    a_lock_irq: assert property (p_lock_irq) else $error("no lock irq");
    property p_mute_irq;
        mute_chg |=> mute_evt;
    endproperty
    a_mute_irq: assert property (p_mute_irq) else $error("no mute evt");
    property p_clear;
        rd_evt && !lock_chg |=> !lock_evt;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_input;
        fn_b == `DGC_FN_IN_LEVEL |=> !general_pin_b_oe;
    endproperty
    a_input: assert property (p_input) else $error("pin b driven");
    property p_slave;
        !master |-> !bit_clock_pin_oe && !serial_line_one_pin_oe;
    endproperty
    a_slave: assert property (p_slave) else $error("clocks driven");
    property p_div4;
        master && div_sel == 2'b00 && $rose(bclk_gen)
            ##1 (master && div_sel == 2'b00)[*3] |->
            !bclk_gen && !$past(bclk_gen) && $past(bclk_gen, 2)
            ##1 bclk_gen;
    endproperty
    a_div4: assert property (p_div4) else $error("div4 period");
    property p_low;
        fn_a == `DGC_FN_LOW |=> !general_pin_a_o;
    endproperty
    a_low: assert property (p_low) else $error("pin a not low");

    c_master: cover property (master && $rose(fclk_gen));
    c_lock_done: cover property ($rose(acq_done));
    c_clear: cover property (rd_evt && lock_evt);

endmodule : dgc_top

// File: tb/dgc_src_model.sv
// serial audio source model: bit clock, frame clock and data
module dgc_src_model #(
    parameter int FH = 4  // sys cycles per frame clock half period
) (
    // clock and stream enable
    input  wire logic clk,
    input  wire logic en,
    // link outputs
    output logic      bclk,
    output logic      fclk,
    output logic      sdat
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cnt  = 0;     // cycles into the half frame
    logic last = 1'b0;  // data bit last driven
    // clocks stand still off-stream, released data shows the inverse
    always @(posedge clk) begin
        if (!en) begin
            bclk <= 1'b0;
            fclk <= 1'b0;
            sdat <= ~last;
            cnt  <= 0;
        end else begin
            bclk <= ~bclk;
            cnt  <= (cnt == FH - 1) ? 0 : cnt + 1;
            if (cnt == FH - 1) fclk <= ~fclk;
            sdat <= fclk;
            last <= fclk;
        end
    end
endmodule : dgc_src_model

// File: tb/dgc_top_tb.sv
// bench for the pin, clock and routing registers
module dgc_top_tb;
    import dgc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, srst = 1'b1;  // clock and reset
    logic [11:0] awa = '0, ara = '0;           // bus addresses
    logic [31:0] wd = '0, rn, d;               // write data, random, read
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic        awr, wrd, bv, arr, rv, msel = 0;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata;
    dgc_stat_s   st = '0;                      // core status levels
    dgc_route_s  rt;
    logic        pa_o, pa_oe, pb_o, pb_oe, bc_o, bc_oe, l1_o, l1_oe;
    logic        pa_x = 0, pb_x = 0, pen = 0, p_bc, p_fc, p_dt;
    logic [3:0]  f, ws = 4'h1;                 // function, write strobes
    logic [4:0]  lv;
    int          num_errors = 0, n_checks = 0, cyc = 0, n;
    int          seed = 76840;
    logic [11:0] ra [4] = '{12'h020, 12'h024, 12'h028, 12'h02C};
    logic [7:0]  re [4] = '{8'h10, 8'h00, 8'h05, 8'h02};
    logic [3:0]  fl [8] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'hF, 4'hA, 4'hE, 4'h8};
    // pin levels from every driver
    wire logic   pa_w = pa_oe ? pa_o : pa_x;
    wire logic   pb_w = pb_oe ? pb_o : pb_x;
    wire logic   bc_w = bc_oe ? bc_o : p_bc;
    wire logic   l1_w = l1_oe ? l1_o : p_fc;
    wire logic   msig = msel ? l1_o : bc_o;   // clock being timed
    always #25 sys_clk = ~sys_clk;
    dgc_top i_dut (
        .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .core_stat(st), .core_route(rt),
        .general_pin_a_i(pa_w), .general_pin_a_o(pa_o),
        .general_pin_a_oe(pa_oe), .general_pin_b_i(pb_w),
        .general_pin_b_o(pb_o), .general_pin_b_oe(pb_oe),
        .bit_clock_pin_i(bc_w), .bit_clock_pin_o(bc_o),
        .bit_clock_pin_oe(bc_oe), .serial_line_one_pin_i(l1_w),
        .serial_line_one_pin_o(l1_o), .serial_line_one_pin_oe(l1_oe),
        .serial_line_two_pin_i(p_dt));
    dgc_src_model i_src (.clk(sys_clk), .en(pen), .bclk(p_bc),
                         .fclk(p_fc), .sdat(p_dt));
    // expected pin level for an output function
    function automatic logic pin_exp(input logic [3:0] c, input dgc_stat_s s);
        case (c)
            4'h0: return s.automute;
            4'h1: return s.locked;
            4'h2: return s.vol_min_left & s.vol_min_right;
            4'hF: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : pin_exp
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task results();
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    // bus write, both channels offered together
    task axw(input logic [11:0] a, input logic [7:0] v);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1;
        wv <= 1;
        br <= 1;
        do begin
            @(posedge sys_clk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while (!bv);
        rs = bresp;
        br <= 0;
        @(posedge sys_clk);
    endtask : axw
    // bus read
    task axr(input logic [11:0] a);
        ara <= a;
        arv <= 1;
        rr <= 1;
        do begin
            @(posedge sys_clk);
            if (arr) arv <= 0;
        end while (!rv);
        d = rdata;
        rs = rresp;
        rr <= 0;
        @(posedge sys_clk);
    endtask : axr
    // half period of the timed clock in sys cycles
    task hp();
        logic p;
        @(posedge sys_clk);
        p = msig;
        while (msig === p) @(posedge sys_clk);
        p = msig;
        n = 0;
        while (msig === p) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : hp
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            axr(ra[i]);
            chk(d, {24'h0, re[i]});
        end
        axw(12'h024, 8'hA5);
        axr(12'h024);
        chk(d, 32'hA5);
        ws <= 4'h0;
        axw(12'h024, 8'h5A);
        ws <= 4'h1;
        axr(12'h024);
        chk(d, 32'h0);
        axr(12'h021);
        chk({rs, d[29:0]}, 32'h80000000);
        axr(12'h030);
        chk({rs, d[29:0]}, 32'h80000000);
        axw(12'h030, 8'h01);
        chk({30'h0, rs}, 32'h2);
        // functions 0, 1, 2, 7, 8, 10, 14 and 15 on both nibbles, random status
        for (int i = 0; i < 8; i++) begin
            f = fl[i];
            axw(12'h020, {f, f});
            for (int k = 0; k < 4; k++) begin
                rn = $random(seed);
                st <= rn[5:0];
                pa_x <= rn[6];
                pb_x <= rn[7];
                repeat (4) @(posedge sys_clk);
                chk({pa_oe, pa_oe & pa_o, pb_oe, pb_oe & pb_o},
                    {2{f != 4'h8, pin_exp(f, st)}});
                if (f == 4'h8) axr(12'h104);
                if (f == 4'h8) chk(d, {30'h0, pb_x, pa_x});
            end
        end
        // change interrupts, cleared by the event read
        for (int i = 0; i < 3; i++) begin
            axw(12'h020, {4'h8, 4'h4 + i[3:0]});
            axr(12'h100);
            if (i != 1) st.locked <= ~st.locked;
            if (i == 1) st.automute <= ~st.automute;
            repeat (4) @(posedge sys_clk);
            chk({31'h0, pa_o}, 32'h1);
            axr(12'h100);
            chk(d[3:0], {st.automute, st.locked, i == 1, i != 1});
            repeat (2) @(posedge sys_clk);
            chk({31'h0, pa_o}, 32'h0);
        end
        // every consumer source code, slot and swap bits
        for (int s = 0; s < 8; s++) begin
            rn = $random(seed);
            axw(12'h02C, {1'b0, s[2:0], rn[3:0]});
            repeat (4) @(posedge sys_clk);
            lv = {pb_w, pa_w, l1_w, p_dt, bc_w};
            chk({rt.right_pair_swap, rt.left_pair_swap, rt.slot_b_source,
                 rt.slot_a_source}, rn[3:0]);
            chk(rt.spdif_stream, s < 5 ? lv[s] : 1'b0);
        end
        // reference clock on pin a, pin b as source select input
        axw(12'h020, 8'h93);
        for (int k = 0; k < 2; k++) begin
            pb_x <= ~pb_x;
            repeat (4) @(posedge sys_clk);
            chk(rt.input_select, pb_x);
        end
        f[0] = pa_o;
        @(posedge sys_clk);
        chk({pa_oe, pa_o ^ f[0]}, 2'h3);
        // master clocks for each divider code
        for (int v = 0; v < 4; v++) begin
            axw(12'h028, {1'b1, v[1:0], 5'h05});
            chk({bc_oe, l1_oe}, 2'h3);
            hp();
            chk(n, v == 0 ? 2 : v == 1 ? 4 : 8);
        end
        msel <= 1;
        hp();
        chk(n, 512);
        axw(12'h028, 8'h05);
        chk({bc_oe, l1_oe}, 2'h0);
        // lock acquisition from the source model frame clock
        st.pcm_normal <= 1;
        st.ratio_128 <= 1;
        pen <= 1;
        axw(12'h028, 8'h15);
        chk(rt.lock_permit, 1'b0);
        repeat (100) @(posedge sys_clk);
        chk(rt.lock_permit, 1'b1);
        axw(12'h028, 8'h0F);
        repeat (8000) @(posedge sys_clk);
        chk(rt.lock_permit, 1'b0);
        repeat (400) @(posedge sys_clk);
        chk(rt.lock_permit, 1'b1);
        axw(12'h028, 8'h00);
        repeat (20) @(posedge sys_clk);
        chk(rt.lock_permit, 1'b0);
        results();
    end
endmodule : dgc_top_tb
